// *** design/elog_defs.svh ***
// Constants of the error-log resource: resource address, control codes,
// offsets, entry field positions and reset values.
// Assumes it is included by its bare name from design and bench files.
`ifndef ELOG_DEFS_SVH
`define ELOG_DEFS_SVH

// Resource address bytes and the read control value
`define ELOG_ADDR_HIGH     8'h7c
`define ELOG_ADDR_LOW      8'hcc
`define ELOG_CTRL_READ     8'h01

// Offset encodings
`define ELOG_INDEX_COUNT   8'h00
`define ELOG_HALF_FIRST    8'h00
`define ELOG_HALF_SECOND   8'h01

// Release status values
`define ELOG_REL_BUSY      2'h0
`define ELOG_REL_DONE      2'h1

// Defining values reported by the resource
`define ELOG_DATA_SIZE     8'h10
`define ELOG_DATA_TYPE     8'h20

// Entry geometry and field positions, bit index of the low byte
`define ELOG_ENTRY_BITS    128
`define ELOG_MSG_BYTES     8
`define ELOG_POS_TIME      0
`define ELOG_POS_TEMP      32
`define ELOG_POS_LED       48
`define ELOG_POS_SUPPLY    64
`define ELOG_POS_SPEED     80
`define ELOG_POS_ACCEL     96
`define ELOG_POS_RSVD      112
`define ELOG_POS_CODE      120
`define ELOG_RSVD_VALUE    8'h00

`endif

// *** design/elog_pkg.sv ***
// Types of the error-log resource: request state machine encoding.
// Assumes elog_defs.svh carries every numeric constant.
package elog_pkg;

  // One-hot states of the parameter read sequencer
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_fetch = 4'b0010,
    st_load  = 4'b0100,
    st_done  = 4'b1000
  } state_type;

endpackage

// *** design/elog_mem_if.sv ***
// Carrier between the log sequencer and the entry store.
// Assumes one clock; write and read ports are independent.
`timescale 1ns/1ns
interface elog_mem_if #(
  parameter int AW = 4,
  parameter int DW = 128
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport writer (output we, output waddr, output wdata, output raddr, input rdata);
  modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** design/elog_store.sv ***
// Entry store of the error log: one write port, one registered read port.
// Assumes a single clock; stands in for the non-volatile array.
`timescale 1ns/1ns
module elog_store #(
  parameter int AW = 4,
  parameter int DW = 128
) (
  input wire logic clk,
  elog_mem_if.store mem
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  // ****************************************
  // Storage and registered read
  // ****************************************
  // No reset: stored entries survive, only the pointers restart
  always_ff @(posedge clk) begin
    if (mem.we) begin
      cells[mem.waddr] <= mem.wdata;
    end
    mem.rdata <= cells[mem.raddr];
  end

endmodule

// *** design/encoder_error_log_access.sv ***
// Error-log resource of an encoder: logs errors into a ring of 16-byte
// entries and answers offset-addressed long-message reads.
// Assumes the request bytes arrive together with a one-cycle strobe,
// all inputs synchronous to clk.
`timescale 1ns/1ns
`include "elog_defs.svh"
module encoder_error_log_access #(
  parameter int ENTRY_ADDR_WIDTH = 4
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        err_valid,
  input  wire logic [7:0]  err_code,
  input  wire logic        setup_err_valid,
  input  wire logic [7:0]  setup_err_code,
  input  wire logic [15:0] acceleration,
  input  wire logic [15:0] rotation_speed,
  input  wire logic [15:0] supply_mv,
  input  wire logic [15:0] led_current,
  input  wire logic [15:0] temperature,
  input  wire logic [31:0] time_stamp,
  input  wire logic        param_write,
  input  wire logic [7:0]  param_resource_addr_high,
  input  wire logic [7:0]  param_resource_addr_low,
  input  wire logic [7:0]  param_offset_high,
  input  wire logic [7:0]  param_offset_low,
  input  wire logic [7:0]  param_transaction_control,
  output logic [1:0]       param_release_status,
  output logic             param_error,
  output logic [7:0]       param_data_byte0,
  output logic [7:0]       param_data_byte1,
  output logic [7:0]       param_data_byte2,
  output logic [7:0]       param_data_byte3,
  output logic [7:0]       param_data_byte4,
  output logic [7:0]       param_data_byte5,
  output logic [7:0]       param_data_byte6,
  output logic [7:0]       param_data_byte7,
  output logic             err_indicate,
  output logic [7:0]       stored_count,
  output logic [7:0]       resource_data_size,
  output logic [7:0]       resource_data_type
);

  localparam int AW      = ENTRY_ADDR_WIDTH;
  localparam int EW      = `ELOG_ENTRY_BITS;
  localparam int ENTRIES = 1 << AW;
  // Index byte is eight bits, so capacity tops out at 255 usable entries
  localparam logic [7:0] CAPACITY = (ENTRIES > 255) ? 8'hff : 8'(ENTRIES);

  elog_mem_if #(.AW(AW), .DW(EW)) mem ();

  elog_store #(.AW(AW), .DW(EW)) store (
    .clk (clk),
    .mem (mem)
  );

  // ****************************************
  // Entry assembly
  // ****************************************
  logic [EW-1:0]   snapshot;
  logic [EW-1:0]   pend_entry;
  logic            pend;
  logic [EW-1:0]   log_entry;
  logic            log_write;
  logic [7:0]      log_code;

  // sample values
  // Process values are taken in the cycle the error is flagged
  assign snapshot[`ELOG_POS_TIME +: 32]   = time_stamp;
  assign snapshot[`ELOG_POS_TEMP +: 16]   = temperature;
  assign snapshot[`ELOG_POS_LED +: 16]    = led_current;
  assign snapshot[`ELOG_POS_SUPPLY +: 16] = supply_mv;
  assign snapshot[`ELOG_POS_SPEED +: 16]  = rotation_speed;
  assign snapshot[`ELOG_POS_ACCEL +: 16]  = acceleration;
  assign snapshot[`ELOG_POS_RSVD +: 8]    = `ELOG_RSVD_VALUE;
  assign snapshot[`ELOG_POS_CODE +: 8]    = log_code;
  // time in low bytes
  // Time occupies bytes 3..0 through the position constant above

  // A live error takes the write slot; a setup error waits in pend for the first cycle without a live error
  assign log_code  = err_valid ? err_code : setup_err_code;
  assign log_write = err_valid | pend;
  assign log_entry = err_valid ? snapshot : pend_entry;

  // setup errors logged
  // Held until a cycle without a live error, so that a simultaneous live error is not lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend       <= 1'b0;
      pend_entry <= '0;
    end else if (setup_err_valid) begin
      pend       <= 1'b1;
      pend_entry <= {setup_err_code, snapshot[EW-9:0]};
    end else if (!err_valid) begin
      pend <= 1'b0;
    end
  end

  // ****************************************
  // Ring pointers
  // ****************************************
  logic [AW-1:0] wr_ptr;
  logic [7:0]    count;
  logic          ring_full;

  assign ring_full = (count == CAPACITY);

  // overwrite oldest
  // The write pointer wraps and the count saturates at capacity
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      count  <= 8'h00;
    end else if (log_write) begin
      wr_ptr <= wr_ptr + 1'b1;
      if (!ring_full) begin
        count <= count + 8'h01;
      end
    end
  end

  assign mem.we    = log_write;
  assign mem.waddr = wr_ptr;
  assign mem.wdata = log_entry;

  // signal the error
  // One-cycle notice towards the drive application per stored error
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_indicate <= 1'b0;
      stored_count <= 8'h00;
    end else begin
      err_indicate <= log_write;
      stored_count <= count;
    end
  end

  // ****************************************
  // Request decode
  // ****************************************
  elog_pkg::state_type state;
  elog_pkg::state_type next_state;
  logic                own_request;
  logic                take;
  logic                want_count;
  logic                bad_half;
  logic                bad_index;
  logic                req_error;
  logic [AW-1:0]       entry_addr;
  logic [AW-1:0]       rd_addr;
  logic                half;

  // master command bytes
  // Only a read of this resource is accepted; other resources are not ours
  assign own_request = (param_resource_addr_high == `ELOG_ADDR_HIGH)
                     & (param_resource_addr_low == `ELOG_ADDR_LOW)
                     & (param_transaction_control == `ELOG_CTRL_READ);
  // Requests are refused while a fetch is still running
  // A write during a fetch is dropped silently, so the master has to wait
  // for release before it sends the next request
  assign take = param_write & own_request
              & (state == elog_pkg::st_idle || state == elog_pkg::st_done);

  assign want_count = (param_offset_low == `ELOG_INDEX_COUNT);
  assign bad_half   = (param_offset_high != `ELOG_HALF_FIRST)
                    & (param_offset_high != `ELOG_HALF_SECOND);
  // capacity bound
  // Count never exceeds capacity, so this also bounds the offset
  // Judged against the live count, so an entry stored in the cycle before
  // a request is already readable
  assign bad_index  = (param_offset_low > count);
  assign req_error  = bad_half | (bad_index & ~want_count);

  // offset selects entry
  // Entry k sits k places behind the write pointer in the ring
  assign entry_addr = wr_ptr - param_offset_low[AW-1:0];

  // ****************************************
  // Read sequencer
  // ****************************************
  // Store read takes a cycle for the address and one for the data
  // Limitation: an error stored in the cycle a request is taken may overwrite the cell
  // to be read, and the answer then shows the newer entry
  always_comb begin
    next_state = state;
    case (state)
      elog_pkg::st_idle,
      elog_pkg::st_done: begin
        if (take) begin
          next_state = (req_error | want_count) ? elog_pkg::st_done : elog_pkg::st_fetch;
        end
      end
      elog_pkg::st_fetch: begin
        next_state = elog_pkg::st_load;
      end
      elog_pkg::st_load: begin
        next_state = elog_pkg::st_done;
      end
      default: begin
        next_state = elog_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= elog_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Address and half are held for the whole fetch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_addr <= '0;
      half    <= 1'b0;
    end else if (take) begin
      rd_addr <= entry_addr;
      // Only bit zero picks the half; the other bits are judged by bad_half
      half    <= param_offset_high[0];
    end
  end

  assign mem.raddr = rd_addr;

  // ****************************************
  // Answer buffer
  // ****************************************
  logic [63:0] msg;
  logic [63:0] fetched;

  // eight-byte halves
  // Half zero carries entry bytes 0..7, half one bytes 8..15
  assign fetched = half ? mem.rdata[EW-1:64] : mem.rdata[63:0];

  // Error answers leave the buffer cleared rather than stale
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msg                  <= 64'h0;
      param_error          <= 1'b0;
      param_release_status <= `ELOG_REL_BUSY;
    end else if (take) begin
      param_error          <= req_error;
      param_release_status <= (req_error | want_count) ? `ELOG_REL_DONE : `ELOG_REL_BUSY;
      msg                  <= (want_count & ~req_error) ? {56'h0, count} : 64'h0;
    end else if (state == elog_pkg::st_load) begin
      msg                  <= fetched;
      param_release_status <= `ELOG_REL_DONE;
    end
  end

  assign param_data_byte0 = msg[7:0];
  assign param_data_byte1 = msg[15:8];
  assign param_data_byte2 = msg[23:16];
  assign param_data_byte3 = msg[31:24];
  assign param_data_byte4 = msg[39:32];
  assign param_data_byte5 = msg[47:40];
  assign param_data_byte6 = msg[55:48];
  assign param_data_byte7 = msg[63:56];

  // ****************************************
  // Defining values
  // ****************************************
  // size and type
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resource_data_size <= `ELOG_DATA_SIZE;
      resource_data_type <= `ELOG_DATA_TYPE;
    end else begin
      resource_data_size <= `ELOG_DATA_SIZE;
      resource_data_type <= `ELOG_DATA_TYPE;
    end
  end

endmodule

// *** tb/elog_monitor.sv ***
// Checker for the error-log resource, bound to its top module.
// Assumes one clock and the async active-low reset resetn.
`timescale 1ns/1ns
`include "elog_defs.svh"
module elog_monitor #(
  parameter int ENTRY_ADDR_WIDTH = 4
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       err_valid,
  input wire logic       setup_err_valid,
  input wire logic       param_write,
  input wire logic [7:0] param_resource_addr_high,
  input wire logic [7:0] param_resource_addr_low,
  input wire logic [7:0] param_offset_high,
  input wire logic [7:0] param_offset_low,
  input wire logic [7:0] param_transaction_control,
  input wire logic [1:0] param_release_status,
  input wire logic       param_error,
  input wire logic [7:0] param_data_byte0,
  input wire logic       err_indicate,
  input wire logic [7:0] stored_count
);
  // Only requests after a finished answer are judged, so the idle state after reset is left out
  wire take = param_write && param_resource_addr_high == `ELOG_ADDR_HIGH && param_resource_addr_low == `ELOG_ADDR_LOW
              && param_transaction_control == `ELOG_CTRL_READ && param_release_status == 2'h1;
  wire cnt_rd = take && param_offset_high == 8'h00 && param_offset_low == 8'h00;
  wire bad = take && (param_offset_high > 8'h01 || param_offset_low > stored_count);
  wire ent_rd = take && !bad && param_offset_low != 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_indicate; err_valid |=> err_indicate; endproperty
  a_indicate: assert property (p_indicate) else $error("no indication after error");
  property p_setup; setup_err_valid && !err_valid ##1 !err_valid |=> err_indicate; endproperty
  a_setup: assert property (p_setup) else $error("setup error not stored");
  property p_capacity; stored_count <= 8'(1 << ENTRY_ADDR_WIDTH); endproperty
  a_capacity: assert property (p_capacity) else $error("count above capacity");
  property p_step; stored_count - $past(stored_count) <= 8'h01; endproperty
  a_step: assert property (p_step) else $error("count jumped or fell");
  property p_count_rd; cnt_rd && !err_valid |=> param_release_status == 2'h1 && !param_error
    && param_data_byte0 == stored_count; endproperty
  a_count_rd: assert property (p_count_rd) else $error("count read wrong");
  property p_entry; ent_rd |=> param_release_status == 2'h0 [*2] ##1 param_release_status == 2'h1 && !param_error;
  endproperty
  a_entry: assert property (p_entry) else $error("entry read walk wrong");
  property p_range; bad |=> param_release_status == 2'h1 && param_error && param_data_byte0 == 8'h00; endproperty
  a_range: assert property (p_range) else $error("bad offset not refused");
  property p_hold; !param_write && param_release_status == 2'h1 |=> $stable(param_data_byte0)
    && param_release_status == 2'h1; endproperty
  a_hold: assert property (p_hold) else $error("answer did not stand");
endmodule

// *** tb/elog_master.sv ***
// Drive-side master model: issues long-message reads of the log.
// Assumes the bench calls request only after reset is released.
`timescale 1ns/1ns
module elog_master (
  input  wire logic       clk,
  input  wire logic [1:0] param_release_status,
  input  wire logic       param_error,
  input  wire logic [7:0] param_data_byte0,
  input  wire logic [7:0] param_data_byte1,
  input  wire logic [7:0] param_data_byte2,
  input  wire logic [7:0] param_data_byte3,
  input  wire logic [7:0] param_data_byte4,
  input  wire logic [7:0] param_data_byte5,
  input  wire logic [7:0] param_data_byte6,
  input  wire logic [7:0] param_data_byte7,
  output logic            param_write = 1'b0,
  output logic [7:0]      param_resource_addr_high = 8'h00,
  output logic [7:0]      param_resource_addr_low = 8'h00,
  output logic [7:0]      param_offset_high = 8'h00,
  output logic [7:0]      param_offset_low = 8'h00,
  output logic [7:0]      param_transaction_control = 8'h00
);
  task automatic request(input logic [7:0] ah, al, oh, ol, output logic [63:0] d, output logic e);
    int n;
    @(posedge clk);
    #1;
    param_write = 1'b1;
    {param_resource_addr_high, param_resource_addr_low, param_offset_high, param_offset_low} = {ah, al, oh, ol};
    param_transaction_control = 8'h01;
    @(posedge clk);
    #1;
    param_write = 1'b0;
    // Released lines show the inverse, so a stale byte cannot pass as a request
    {param_resource_addr_high, param_resource_addr_low, param_offset_high, param_offset_low} = ~{ah, al, oh, ol};
    param_transaction_control = 8'hfe;
    n = 0;
    while (param_release_status !== 2'h1 && n < 16) begin
      @(posedge clk);
      #1;
      n++;
    end
    // one message, eight bytes
    // A missing answer hands back unknown data, which every compare refuses
    d = (n < 16) ? {param_data_byte7, param_data_byte6, param_data_byte5, param_data_byte4,
                    param_data_byte3, param_data_byte2, param_data_byte1, param_data_byte0} : 64'hx;
    e = (n < 16) ? param_error : 1'bx;
  endtask
endmodule

// *** tb/encoder_error_log_access_tb.sv ***
// Testbench of the error-log resource: logs errors and reads them back.
// Assumes elog_master and elog_monitor are compiled before it.
`timescale 1ns/1ns
module encoder_error_log_access_tb;
  localparam int CAP = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic err_valid = 1'b0, setup_err_valid = 1'b0, param_write, param_error, err_indicate;
  logic [7:0] err_code = 8'h00, setup_err_code = 8'h00, stored_count, resource_data_size, resource_data_type;
  logic [7:0] param_resource_addr_high, param_resource_addr_low, param_offset_high, param_offset_low;
  logic [7:0] param_transaction_control, param_data_byte0, param_data_byte1, param_data_byte2, param_data_byte3;
  logic [7:0] param_data_byte4, param_data_byte5, param_data_byte6, param_data_byte7;
  logic [15:0] acceleration = 16'h0000, rotation_speed = 16'h0000, supply_mv = 16'h0000;
  logic [15:0] led_current = 16'h0000, temperature = 16'h0000;
  logic [31:0] time_stamp = 32'h0000_0000;
  logic [1:0] param_release_status;
  logic [127:0] log_q[$];
  int n_fail = 0;
  int checked = 0;

  encoder_error_log_access #(.ENTRY_ADDR_WIDTH(2)) dut (.*);
  elog_master master (.*);

  always #10 clk = ~clk;

  // Entry bytes 15..0: code, reserved, accel, speed, supply, led, negative temp, time
  function automatic logic [127:0] entry_of(input logic [7:0] c);
    return {c, 8'h00, c, 8'h0a, c, 8'h0b, c, 8'h0c, c, 8'h0d, 8'hff, c, c, 24'h123456};
  endfunction

  task automatic chk_msg(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_msg({56'h0, got}, {56'h0, exp});
  endtask

  // Newest entry goes first; the oldest drops out once the ring is full
  // A live and a setup error together: live stored first, setup one newest
  task automatic log_err(input logic [7:0] c, input logic live, input logic setup);
    logic [127:0] x;
    x = entry_of(c);
    @(posedge clk);
    #1;
    {acceleration, rotation_speed, supply_mv, led_current, temperature, time_stamp} = x[111:0];
    err_code = c;
    setup_err_code = c + 8'h01;
    err_valid = live;
    setup_err_valid = setup;
    @(posedge clk);
    #1;
    err_valid = 1'b0;
    setup_err_valid = 1'b0;
    repeat (3) @(posedge clk);
    if (live) log_q.push_front(x);
    x[127:120] = c + 8'h01;
    if (setup) log_q.push_front(x);
    while (log_q.size() > CAP) void'(log_q.pop_back());
  endtask

  task automatic t_after_reset;
    logic [63:0] d;
    logic e;
    chk_byte(resource_data_size, 8'h10);
    chk_byte(resource_data_type, 8'h20);
    master.request(8'h7c, 8'hcc, 8'h00, 8'h00, d, e);
    chk_msg(d, 64'h0);
  endtask

  task automatic t_read_all;
    logic [63:0] d;
    logic e;
    logic [127:0] x;
    master.request(8'h7c, 8'hcc, 8'h00, 8'h00, d, e);
    chk_msg(d, {56'h0, 8'(log_q.size())});
    for (int i = 1; i <= log_q.size(); i++) begin
      x = log_q[i-1];
      master.request(8'h7c, 8'hcc, 8'h00, 8'(i), d, e);
      chk_msg(d, x[63:0]);
      master.request(8'h7c, 8'hcc, 8'h01, 8'(i), d, e);
      chk_msg(d, x[127:64]);
      chk_byte({7'h00, e}, 8'h00);
    end
  endtask

  task automatic t_bad;
    logic [63:0] d;
    logic e;
    logic [127:0] x;
    master.request(8'h7c, 8'hcc, 8'h00, 8'h05, d, e);
    chk_msg(d, 64'h0);
    chk_byte({7'h00, e}, 8'h01);
    master.request(8'h7c, 8'hcc, 8'h02, 8'h01, d, e);
    chk_byte({7'h00, e}, 8'h01);
    chk_msg(d, 64'h0);
    x = log_q[0];
    master.request(8'h7c, 8'hcc, 8'h01, 8'h01, d, e);
    chk_msg(d, x[127:64]);
    master.request(8'h7c, 8'h00, 8'h00, 8'h02, d, e);
    chk_msg(d, x[127:64]);
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_after_reset;
    log_err(8'h11, 1'b1, 1'b0);
    log_err(8'h22, 1'b0, 1'b1);
    log_err(8'h33, 1'b1, 1'b0);
    t_read_all;
    log_err(8'h44, 1'b1, 1'b0);
    log_err(8'h55, 1'b0, 1'b1);
    log_err(8'h66, 1'b1, 1'b0);
    log_err(8'h77, 1'b1, 1'b1);
    t_read_all;
    t_bad;
    give_verdict;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    give_verdict;
  end
endmodule

bind encoder_error_log_access elog_monitor #(.ENTRY_ADDR_WIDTH(ENTRY_ADDR_WIDTH)) mon (.*);
